// ==== design/ecss_edge_clock_stop_sync_cell.sv ====
// Glitch-free run-time stop and restart gate for one edge clock.
`timescale 1ns/1ns
`default_nettype none

module ecss_edge_clock_stop_sync_cell
    import ecss_pkg::*;
#(
    parameter int unsigned SYNC_STAGES = ECSS_SYNC_STAGES
) (
    // Edge clock in and synchronous reset.
    input  wire logic edge_clk_in,
    input  wire logic nrst,
    // Stop control from core logic, asynchronous.
    input  wire logic stop,
    // Gated edge clock and gate status.
    output logic      edge_clk_out,
    output logic      clk_stopped
);

    // The agreement test of the synchronisers needs three stages at least.
    initial begin
        if (SYNC_STAGES < 3) begin
            $error("ecss_edge_clock_stop_sync_cell needs SYNC_STAGES of three or more");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers.

    logic neg_level;
    logic neg_stable;
    logic pos_level;
    logic pos_stable;

    // stop synchroniser
    // The falling-edge chain times the stop so the gate closes at falling edge four.
    ecss_sync #(
        .STAGES   (SYNC_STAGES),
        .FALLING  (1'b1)
    ) u_sync_stop (
        .clk      (edge_clk_in),
        .nrst     (nrst),
        .async_in (stop),
        .level    (neg_level),
        .stable   (neg_stable)
    );

    // release synchroniser
    // The rising-edge chain times the release so the gate opens before rising edge four.
    ecss_sync #(
        .STAGES   (SYNC_STAGES),
        .FALLING  (1'b0)
    ) u_sync_release (
        .clk      (edge_clk_in),
        .nrst     (nrst),
        .async_in (stop),
        .level    (pos_level),
        .stable   (pos_stable)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Gate state, changed only on the falling edge.

    ecss_state_type st_q;
    ecss_state_type st_d;

    always_comb begin
        st_d = st_q;
        case (st_q.mode)
            ECSS_RUN: begin
                if (neg_stable && neg_level) begin
                    st_d.mode    = ECSS_STOPPED;
                    st_d.en      = 1'b0;
                    st_d.stopped = 1'b1;
                end
            end
            ECSS_STOPPED: begin
                st_d.en = 1'b0;
                // reopen gate
                // Opening on the falling edge after rising edge three lets rising edge four pass.
                if (!pos_level && pos_stable) begin
                    st_d.mode    = ECSS_RESTART;
                    st_d.en      = 1'b1;
                    st_d.stopped = 1'b0;
                end
            end
            ECSS_RESTART: begin
                st_d.mode    = ECSS_RUN;
                st_d.en      = 1'b1;
                st_d.stopped = 1'b0;
            end
            default: begin
                st_d.mode    = ECSS_RUN;
                st_d.en      = ECSS_EN_RST;
                st_d.stopped = 1'b0;
            end
        endcase
        if (!nrst) begin
            st_d.mode    = ECSS_RUN;
            st_d.en      = ECSS_EN_RST;
            st_d.stopped = 1'b0;
        end
    end

    // glitch free
    // The enable only changes while the input clock is low, so no pulse is cut.
    always_ff @(negedge edge_clk_in) begin
        st_q <= st_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign edge_clk_out = edge_clk_in & st_q.en;
    assign clk_stopped  = st_q.stopped;

endmodule : ecss_edge_clock_stop_sync_cell

`default_nettype wire

// ==== design/ecss_pkg.sv ====
// Constants shared by the edge clock stop and synchronise cell.
package ecss_pkg;

    // Number of flip-flops in each stop-input synchroniser chain.
    localparam int unsigned ECSS_SYNC_STAGES = 3;

    // Value that each synchroniser flip-flop takes at reset (stop released).
    localparam logic ECSS_SYNC_RST = 1'h0;

    // Value of the gate enable at reset: the clock passes.
    localparam logic ECSS_EN_RST = 1'h1;

    // Gate state, coded in binary.
    typedef enum logic [1:0] {
        ECSS_RUN      = 2'h0,
        ECSS_STOPPED  = 2'h1,
        ECSS_RESTART  = 2'h2
    } ecss_mode_type;

    // Gate state of the gating cell (mode, enable, status), updated on the falling edge.
    typedef struct packed {
        ecss_mode_type mode;
        logic          en;
        logic          stopped;
    } ecss_state_type;

endpackage : ecss_pkg

// ==== design/ecss_sync.sv ====
// Three-stage synchroniser for an asynchronous level, on either clock edge.
`timescale 1ns/1ns
`default_nettype none

module ecss_sync
    import ecss_pkg::*;
#(
    parameter int unsigned STAGES   = ECSS_SYNC_STAGES,
    parameter bit          FALLING  = 1'b0
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic nrst,
    // Asynchronous level in.
    input  wire logic async_in,
    // Agreed level and agreement flag out.
    output logic      level,
    output logic      stable
);

    // The agreement test reads the last two stages only.
    initial begin
        if (STAGES < 3) begin
            $error("ecss_sync needs at least three stages");
        end
    end

    logic [STAGES-1:0] chain_q;
    logic [STAGES-1:0] chain_d;

    always_comb begin
        chain_d = {chain_q[STAGES-2:0], async_in};
        if (!nrst) begin
            chain_d = {STAGES{ECSS_SYNC_RST}};
        end
    end

    generate
        if (FALLING) begin : g_neg
            always_ff @(negedge clk) begin
                chain_q <= chain_d;
            end
        end else begin : g_pos
            always_ff @(posedge clk) begin
                chain_q <= chain_d;
            end
        end
    endgenerate

    // A change counts once the last two stages agree.
    assign level  = chain_q[STAGES-1];
    assign stable = (chain_q[STAGES-1] == chain_q[STAGES-2]);

endmodule : ecss_sync

`default_nettype wire

// ==== testbench/ecss_cell_asserts.sv ====
// Timing checker of the edge clock stop cell.
`timescale 1ns/1ns
`default_nettype none
module ecss_cell_asserts (
    // Clock, reset, stop.
    input wire logic edge_clk_in,
    input wire logic nrst,
    input wire logic stop,
    // Gated clock, status.
    input wire logic edge_clk_out,
    input wire logic clk_stopped
);
    default clocking dc @(negedge edge_clk_in);
    endclocking
    default disable iff (!nrst);
    chk_gate_closes: assert property (stop[*8] |-> clk_stopped)
        else $error("gate open under stop");
    chk_sync_delay: assert property ($rose(clk_stopped) |-> $past(stop, 2) && $past(stop, 3))
        else $error("gate closed too early");
    chk_out_follows: assert property (edge_clk_out != clk_stopped)
        else $error("high phase lost or leaked");
    chk_restart_time: assert property (stop[*8] ##1 !stop[*6] |->
        edge_clk_out && $past(edge_clk_out, 1) && !$past(edge_clk_out, 2))
        else $error("restart off time");
    chk_low_phase: assert property (@(posedge edge_clk_in) !edge_clk_out)
        else $error("pulse in low phase");
endmodule : ecss_cell_asserts
bind ecss_edge_clock_stop_sync_cell ecss_cell_asserts chk (.edge_clk_in(edge_clk_in),
    .nrst(nrst), .stop(stop), .edge_clk_out(edge_clk_out), .clk_stopped(clk_stopped));
`default_nettype wire

// ==== testbench/ecss_core_model.sv ====
// Core logic model that holds and releases the stop control.
`timescale 1ns/1ns
`default_nettype none
module ecss_core_model (
    // Clock and wished level.
    input  wire logic clk,
    input  wire logic req,
    // Stop to the cell.
    output var logic  stop
);
    initial stop = 1'h0;
    always @(posedge clk) begin
        stop <= req;
    end
endmodule : ecss_core_model
`default_nettype wire

// ==== testbench/ecss_edge_clock_stop_sync_test.sv ====
// Random stop and release spans for the edge clock stop cell.
`timescale 1ns/1ns
`default_nettype none
module ecss_edge_clock_stop_sync_test;
    logic        edge_clk_in = 1'h0;
    logic        nrst = 1'h0;
    logic        req = 1'h0;
    logic        stop;
    logic        edge_clk_out;
    logic        clk_stopped;
    logic [31:0] lv = 32'hc346c263;
    int          err_total = 0;
    int          cmp_count = 0;
    int          span;
    initial begin
        forever #5 edge_clk_in = ~edge_clk_in;
    end
    ecss_core_model core (.clk(edge_clk_in), .req(req), .stop(stop));
    ecss_edge_clock_stop_sync_cell dut (.edge_clk_in(edge_clk_in), .nrst(nrst), .stop(stop),
        .edge_clk_out(edge_clk_out), .clk_stopped(clk_stopped));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic check(input string what, input logic seen, input logic exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %b seen %b", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (16) @(posedge edge_clk_in);
        nrst <= 1'h1;
        for (int i = 0; i < 60; i++) begin
            lv = lfsr(lv);
            span = (i < 4) ? 16 : int'(lv[3:0]) + 2;
            @(posedge edge_clk_in);
            req <= ~req;
            for (int k = 1; k <= span; k++) begin
                @(posedge edge_clk_in);
                if (i < 4 && (k == 4 || k == 5)) begin
                    #2;
                    check("edge_clk_out_edge", edge_clk_out, (k == 4) ? req : ~req);
                end
            end
            if (span >= 10) begin
                #2;
                check("clk_stopped", clk_stopped, req);
                check("edge_clk_out", edge_clk_out, ~req);
            end
        end
        tally_and_finish();
    end
    initial begin
        #60000;
        err_total++;
        tally_and_finish();
    end
endmodule : ecss_edge_clock_stop_sync_test
`default_nettype wire
